// ===== inc/sfpw_pkg.sv
package sfpw_pkg;

	// Timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int PAGE_WRITE_TIME_NS = 800000;
	localparam int PAGE_WRITE_CYCLES = PAGE_WRITE_TIME_NS / CLK_PERIOD_NS;

	// Geometry
	localparam int PAGE_BYTES = 256;
	localparam int PAGE_NUM_BITS = 16;
	localparam int BUF_WIDTH = 32;
	localparam logic [8:0] SECTOR_COUNT = 9'h100;
	localparam logic [3:0] BP_ALL_PROTECTED = 4'h9;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;

	// Opcodes
	localparam logic [7:0] OP_WRITE_ENABLE_COMMAND = 8'h06;
	localparam logic [7:0] OP_SINGLE_LINE_PAGE_WRITE = 8'h02;
	localparam logic [7:0] OP_TWO_LINE_DATA_PAGE_WRITE = 8'hA2;
	localparam logic [7:0] OP_TWO_LINE_ADDR_DATA_PAGE_WRITE = 8'hD2;
	localparam logic [7:0] OP_FOUR_LINE_DATA_PAGE_WRITE = 8'h32;
	localparam logic [7:0] OP_FOUR_LINE_ADDR_DATA_PAGE_WRITE = 8'h12;
	localparam logic [7:0] OP_READ_STATUS = 8'h05;
	localparam logic [7:0] OP_READ_FLAG_STATUS = 8'h70;
	localparam logic [7:0] OP_PROGRAM_ERASE_SUSPEND_CMD = 8'h75;
	localparam logic [7:0] OP_PROGRAM_ERASE_RESUME_CMD = 8'h7A;

	// Lane counts
	localparam logic [2:0] LANES_1 = 3'h1;
	localparam logic [2:0] LANES_2 = 3'h2;
	localparam logic [2:0] LANES_4 = 3'h4;

	// Status byte layout
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_WEL_BIT = 1;
	localparam int STAT_BP_LSB = 2;
	localparam int STAT_TOP_BOTTOM_BIT = 6;
	localparam int FLAG_READY_BIT = 7;
	localparam int FLAG_SUSPENDED_BIT = 2;

	typedef enum logic [4:0] {
		ST_OPCODE = 5'h01,
		ST_ADDR   = 5'h02,
		ST_DATA   = 5'h04,
		ST_STATUS = 5'h08,
		ST_IGNORE = 5'h10
	} sfpw_link_state_type;

	typedef enum logic [2:0] {
		PG_IDLE = 3'h1,
		PG_RUN  = 3'h2,
		PG_SUSP = 3'h4
	} sfpw_prog_state_type;

endpackage

// ===== hdl/sfpw_skid_buffer.sv
`timescale 1ns/10ps
`default_nettype none

module sfpw_skid_buffer #(
	parameter int WIDTH = 32
) (
	// Clock and reset
	input  wire logic             clk_sys_i,
	input  wire logic             reset_i,
	// Filling side
	input  wire logic             in_valid_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  in_ready_o,
	// Draining side
	output logic                  out_valid_o,
	output logic      [WIDTH-1:0] out_data_o,
	input  wire logic             out_ready_i
);

	typedef struct packed {
		logic             out_valid;
		logic [WIDTH-1:0] out_data;
		logic             skid_valid;
		logic [WIDTH-1:0] skid_data;
	} sfpw_buf_state_type;

	sfpw_buf_state_type r;
	sfpw_buf_state_type n;

	// Ready is registered so the source never sees a combinational path
	always_comb begin
		n = r;
		if (out_ready_i || !r.out_valid) begin
			if (r.skid_valid) begin
				n.out_valid = 1'b1;
				n.out_data = r.skid_data;
				n.skid_valid = 1'b0;
			end else begin
				n.out_valid = in_valid_i;
				n.out_data = in_data_i;
			end
		end else if (in_valid_i && !r.skid_valid) begin
			n.skid_valid = 1'b1;
			n.skid_data = in_data_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign in_ready_o = !r.skid_valid;
	assign out_valid_o = r.out_valid;
	assign out_data_o = r.out_data;

endmodule

`default_nettype wire

// ===== hdl/sfpw_page_write.sv
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// R1: Program accepted only with write enable set
// R2: Host sends opcode, three address, data bytes
// R3: Data past page end wraps to byte zero
// R4: Over 256 bytes: last 256 kept
// R5: Unsent bytes of page stay unchanged
// R6: Host keeps select low whole sequence
// R7: Select rise off byte boundary cancels program
// R8: Valid select rise starts timed program cycle
// R9: Status reads answered during program cycle
// R10: Busy bit high throughout cycle, then low
// R11: Write enable cleared before cycle ends
// R12: Protected target page refuses program
// R13: Suspend pauses cycle, resume continues it
// R14: Programming only clears bits to zero
// R15: Two-line data variant: data on lines 0-1
// R16: Two-line extended variant: address too
// R17: Four-line data variant: data on lines 0-3
// R18: Four-line extended variant: address too
// R19: Host prefers long sequences over short ones
// R20: Host sets latch with bare enable command
// R21: Completed program leaves write enable cleared
// R22: Rising clock samples, MSB first, high lines
// R23: New program ignored while cycle runs
module sfpw_page_write
	import sfpw_pkg::*;
#(
	parameter int PAGE_WRITE_CYC = PAGE_WRITE_CYCLES
) (
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        reset_i,
	// Serial link
	input  wire logic        chip_select_n_i,
	input  wire logic        serial_clock_i,
	input  wire logic [3:0]  serial_io_i,
	output logic      [3:0]  serial_io_o,
	output logic      [3:0]  serial_io_oe_o,
	// Protection configuration
	input  wire logic [3:0]  block_protect_i,
	input  wire logic        protect_top_bottom_select_i,
	// Memory array clear port
	output logic             mem_valid_o,
	output logic      [23:0] mem_addr_o,
	output logic      [7:0]  mem_clear_bits_o,
	input  wire logic        mem_ready_i,
	// Status
	output logic             write_enable_latch_o,
	output logic             write_in_progress_flag_o,
	output logic             program_suspended_o
);

	localparam int TW = $clog2(PAGE_WRITE_CYC + 1);
	localparam logic [TW-1:0] TIMER_LAST = TW'(PAGE_WRITE_CYC - 1);
	localparam logic [TW-1:0] TIMER_ONE = TW'(1);

	typedef struct packed {
		logic                          cs_s1;
		logic                          cs_s2;
		logic                          cs_d;
		logic                          sclk_s1;
		logic                          sclk_s2;
		logic                          sclk_d;
		logic [3:0]                    io_s1;
		logic [3:0]                    io_s2;
		sfpw_link_state_type           lstate;
		logic [7:0]                    opcode;
		logic [7:0]                    shreg;
		logic [3:0]                    bitcnt;
		logic [1:0]                    addr_cnt;
		logic [PAGE_NUM_BITS-1:0]      page_num;
		logic [2:0]                    addr_lanes;
		logic [2:0]                    data_lanes;
		logic                          got_data;
		logic                          bare;
		logic [PAGE_BYTES-1:0][7:0]    page_data;
		logic [PAGE_BYTES-1:0]         page_mask;
		logic [7:0]                    wr_idx;
		logic                          write_enable_latch;
		sfpw_prog_state_type           pstate;
		logic [TW-1:0]                 timer;
		logic [8:0]                    scan_idx;
		logic [7:0]                    stat_sh;
		logic [3:0]                    io_o;
		logic [3:0]                    io_oe;
		logic                          busy;
		logic                          susp;
	} sfpw_state_type;

	sfpw_state_type r;
	sfpw_state_type n;

	logic                 rise;
	logic                 fall;
	logic                 cs_rise;
	logic                 sel;
	logic [2:0]           lanes;
	logic [3:0]           cnt;
	logic [7:0]           sh;
	logic                 byte_done;
	logic [7:0]           stat;
	logic [7:0]           flg;
	logic [7:0]           sbyte;
	logic [7:0]           idx;
	logic                 push;
	logic                 buf_in_ready;
	logic [BUF_WIDTH-1:0] buf_in;
	logic [BUF_WIDTH-1:0] buf_out;

	// Chunk enters at the low end, highest line carries the higher bit
	function automatic logic [7:0] sfpw_shift(
		input logic [7:0] cur,
		input logic [3:0] io,
		input logic [2:0] w
	);
		logic [7:0] res;
		case (w)
			LANES_4: res = {cur[3:0], io};
			LANES_2: res = {cur[5:0], io[1:0]};
			default: res = {cur[6:0], io[0]};
		endcase
		return res;
	endfunction

	// Protected span grows from the top or bottom in powers of two sectors
	function automatic logic sfpw_protected(
		input logic [7:0] sector,
		input logic [3:0] bp,
		input logic       bottom
	);
		logic [8:0] span;
		logic       p;
		span = 9'h000;
		p = 1'b0;
		if (bp >= BP_ALL_PROTECTED) begin
			p = 1'b1;
		end else if (bp != 4'h0) begin
			span = 9'h001 << (bp - 4'h1);
			if (bottom) begin
				p = {1'b0, sector} < span;
			end else begin
				p = {1'b0, sector} >= (SECTOR_COUNT - span);
			end
		end
		return p;
	endfunction

	always_comb begin
		n = r;
		n.cs_s1 = chip_select_n_i;
		n.cs_s2 = r.cs_s1;
		n.cs_d = r.cs_s2;
		n.sclk_s1 = serial_clock_i;
		n.sclk_s2 = r.sclk_s1;
		n.sclk_d = r.sclk_s2;
		n.io_s1 = serial_io_i;
		n.io_s2 = r.io_s1;

		rise = r.sclk_s2 && !r.sclk_d; // R22
		fall = !r.sclk_s2 && r.sclk_d;
		cs_rise = r.cs_s2 && !r.cs_d;
		sel = !r.cs_s2;
		idx = r.scan_idx[7:0];
		push = 1'b0;
		sh = 8'h00;
		cnt = 4'h0;
		byte_done = 1'b0;

		case (r.lstate)
			ST_ADDR: lanes = r.addr_lanes; // R16 R18
			ST_DATA: lanes = r.data_lanes; // R15 R17
			default: lanes = LANES_1;
		endcase

		stat = 8'h00;
		stat[STAT_BUSY_BIT] = r.busy;
		stat[STAT_WEL_BIT] = r.write_enable_latch;
		stat[STAT_BP_LSB +: 4] = block_protect_i;
		stat[STAT_TOP_BOTTOM_BIT] = protect_top_bottom_select_i;
		flg = 8'h00;
		flg[FLAG_READY_BIT] = !r.busy;
		flg[FLAG_SUSPENDED_BIT] = r.susp;
		sbyte = (r.opcode == OP_READ_FLAG_STATUS) ? flg : stat;

		if (!sel) begin
			if (cs_rise) begin
				// Only a whole byte with data behind it starts the cycle
				if (r.lstate == ST_DATA && r.got_data &&
						r.bitcnt == 4'h0) begin // R7
					n.pstate = PG_RUN; // R8
					n.timer = '0;
					n.scan_idx = 9'h000;
					n.write_enable_latch = 1'b0; // R11 R21
				end else if (r.lstate == ST_IGNORE && r.bare) begin
					case (r.opcode)
						OP_WRITE_ENABLE_COMMAND: begin
							if (!r.busy) begin
								n.write_enable_latch = 1'b1; // R20
							end
						end
						OP_PROGRAM_ERASE_SUSPEND_CMD: begin
							if (r.pstate == PG_RUN) begin
								n.pstate = PG_SUSP; // R13
							end
						end
						OP_PROGRAM_ERASE_RESUME_CMD: begin
							if (r.pstate == PG_SUSP) begin
								n.pstate = PG_RUN; // R13
							end
						end
						default: begin
						end
					endcase
				end
			end
			n.lstate = ST_OPCODE;
			n.bitcnt = 4'h0;
			n.addr_cnt = 2'h0;
			n.got_data = 1'b0;
			n.bare = 1'b0;
			n.io_oe = 4'h0;
			n.io_o = 4'h0;
		end else if (rise && r.lstate != ST_STATUS) begin
			sh = sfpw_shift(r.shreg, r.io_s2, lanes); // R22
			cnt = r.bitcnt + {1'b0, lanes};
			byte_done = (cnt == BITS_PER_BYTE);
			n.shreg = sh;
			n.bitcnt = byte_done ? 4'h0 : cnt;
			case (r.lstate)
				ST_OPCODE: begin
					if (byte_done) begin
						n.opcode = sh;
						n.lstate = ST_IGNORE;
						n.bare = 1'b1;
						n.addr_lanes = LANES_1;
						n.data_lanes = LANES_1;
						case (sh)
							OP_SINGLE_LINE_PAGE_WRITE: begin
								n.lstate = ST_ADDR;
							end
							OP_TWO_LINE_DATA_PAGE_WRITE: begin
								n.lstate = ST_ADDR;
								n.data_lanes = LANES_2; // R15
							end
							OP_TWO_LINE_ADDR_DATA_PAGE_WRITE: begin
								n.lstate = ST_ADDR;
								n.addr_lanes = LANES_2; // R16
								n.data_lanes = LANES_2;
							end
							OP_FOUR_LINE_DATA_PAGE_WRITE: begin
								n.lstate = ST_ADDR;
								n.data_lanes = LANES_4; // R17
							end
							OP_FOUR_LINE_ADDR_DATA_PAGE_WRITE: begin
								n.lstate = ST_ADDR;
								n.addr_lanes = LANES_4; // R18
								n.data_lanes = LANES_4;
							end
							OP_READ_STATUS,
							OP_READ_FLAG_STATUS: begin
								n.lstate = ST_STATUS; // R9
								n.io_oe = 4'h2;
							end
							default: begin
							end
						endcase
						// Program without latch or during a cycle is dropped
						if (n.lstate == ST_ADDR &&
								(!r.write_enable_latch || r.busy)) begin // R1 R23
							n.lstate = ST_IGNORE;
							n.bare = 1'b0;
						end
					end
				end
				ST_ADDR: begin
					if (byte_done) begin
						n.addr_cnt = r.addr_cnt + 2'h1;
						n.page_num = {r.page_num[7:0], sh};
						if (r.addr_cnt == ADDR_LAST_BYTE) begin
							n.page_num = r.page_num;
							n.wr_idx = sh;
							n.page_mask = '0;
							n.lstate = ST_DATA;
							if (sfpw_protected(r.page_num[15:8],
									block_protect_i,
									protect_top_bottom_select_i)) begin
								n.lstate = ST_IGNORE; // R12
							end
						end
					end
				end
				ST_DATA: begin
					if (byte_done) begin
						// Later bytes overwrite earlier ones at the same slot
						n.page_data[r.wr_idx] = sh; // R4
						n.page_mask[r.wr_idx] = 1'b1; // R5
						n.wr_idx = r.wr_idx + 8'h01; // R3
						n.got_data = 1'b1;
					end
				end
				default: begin
					n.bare = 1'b0;
				end
			endcase
		end else if (fall && r.lstate == ST_STATUS) begin
			// Reload each byte so the host sees the live busy bit
			if (r.bitcnt == 4'h0) begin
				n.io_o[1] = sbyte[7]; // R9
				n.stat_sh = {sbyte[6:0], 1'b0};
			end else begin
				n.io_o[1] = r.stat_sh[7];
				n.stat_sh = {r.stat_sh[6:0], 1'b0};
			end
			n.bitcnt = {1'b0, r.bitcnt[2:0] + 3'h1};
		end

		case (r.pstate)
			PG_RUN: begin
				if (r.timer != TIMER_LAST) begin
					n.timer = r.timer + TIMER_ONE;
				end
				if (!r.scan_idx[8]) begin
					// Untouched slots are skipped, never rewritten
					push = r.page_mask[idx]; // R5
					if (!push || buf_in_ready) begin
						n.scan_idx = r.scan_idx + 9'h001;
					end
				end else if (r.timer == TIMER_LAST && !mem_valid_o &&
						buf_in_ready) begin
					n.pstate = PG_IDLE; // R10
				end
			end
			PG_SUSP: begin
			end
			PG_IDLE: begin
			end
			default: begin
				n.pstate = PG_IDLE;
			end
		endcase

		n.busy = (n.pstate != PG_IDLE); // R10
		n.susp = (n.pstate == PG_SUSP);
	end

	// Array may only clear cells, so hand it the bits that must go low
	assign buf_in = {r.page_num, idx, ~r.page_data[idx]}; // R14

	sfpw_skid_buffer #(
		.WIDTH(BUF_WIDTH)
	) u_clear_buffer (
		.clk_sys_i  (clk_sys_i),
		.reset_i    (reset_i),
		.in_valid_i (push),
		.in_data_i  (buf_in),
		.in_ready_o (buf_in_ready),
		.out_valid_o(mem_valid_o),
		.out_data_o (buf_out),
		.out_ready_i(mem_ready_i)
	);

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			r <= '0;
			r.cs_s1 <= 1'b1;
			r.cs_s2 <= 1'b1;
			r.cs_d <= 1'b1;
			r.lstate <= ST_OPCODE;
			r.pstate <= PG_IDLE;
			r.scan_idx <= 9'h100;
		end else begin
			r <= n;
		end
	end

	assign serial_io_o = r.io_o;
	assign serial_io_oe_o = r.io_oe;
	assign mem_addr_o = buf_out[31:8];
	assign mem_clear_bits_o = buf_out[7:0];
	assign write_enable_latch_o = r.write_enable_latch;
	assign write_in_progress_flag_o = r.busy;
	assign program_suspended_o = r.susp;

endmodule

`default_nettype wire

// ===== tb/sfpw_page_write_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module sfpw_page_write_asserts #(
	parameter int PAGE_WRITE_CYC = 64
) (
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        reset_i,
	// Watched ports
	input  wire logic        chip_select_n_i,
	input  wire logic [3:0]  serial_io_oe_o,
	input  wire logic        mem_valid_o,
	input  wire logic [23:0] mem_addr_o,
	input  wire logic [7:0]  mem_clear_bits_o,
	input  wire logic        mem_ready_i,
	input  wire logic        write_enable_latch_o,
	input  wire logic        write_in_progress_flag_o,
	input  wire logic        program_suspended_o
);
	int run_cnt;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);

	// Suspended time does not count towards the cycle length
	always_ff @(posedge clk_sys_i)
		if (reset_i || !write_in_progress_flag_o)
			run_cnt <= 0;
		else if (!program_suspended_o)
			run_cnt <= run_cnt + 1;

	busy_length_a: assert property (
		$fell(write_in_progress_flag_o) |-> run_cnt >= PAGE_WRITE_CYC - 1)
		else $error("program cycle too short");
	latch_clear_a: assert property (
		$rose(write_in_progress_flag_o) |-> !write_enable_latch_o)
		else $error("latch still set at cycle start");
	start_select_a: assert property (
		$rose(write_in_progress_flag_o) |-> chip_select_n_i &&
		!$past(chip_select_n_i, 6))
		else $error("cycle start not after select rise");
	oe_idle_a: assert property (
		chip_select_n_i [*5] |-> serial_io_oe_o == 4'h0)
		else $error("line driven outside frame");
	oe_lanes_a: assert property (
		serial_io_oe_o[3:2] == 2'h0 && !serial_io_oe_o[0])
		else $error("input line driven");
	mem_hold_a: assert property (
		mem_valid_o && !mem_ready_i |=> mem_valid_o &&
		$stable(mem_addr_o) && $stable(mem_clear_bits_o))
		else $error("clear request lost under stall");
	mem_busy_a: assert property (
		mem_valid_o |-> write_in_progress_flag_o)
		else $error("array write outside cycle");
	susp_busy_a: assert property (
		program_suspended_o |-> write_in_progress_flag_o)
		else $error("suspended while idle");
	latch_set_a: assert property (
		$rose(write_enable_latch_o) |->
		!write_in_progress_flag_o && chip_select_n_i)
		else $error("latch set while busy");

	cover property ($rose(write_in_progress_flag_o));
	cover property ($rose(program_suspended_o));
	cover property (mem_valid_o && !mem_ready_i);
endmodule

`default_nettype wire

// ===== tb/sfpw_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module sfpw_host_model (
	// Clock
	input  wire logic clk_sys_i,
	// Link
	output logic       chip_select_n_o,
	output logic       serial_clock_o,
	output logic [3:0] serial_io_o,
	input  wire logic  status_line_i
);
	initial begin
		chip_select_n_o = 1'b1;
		serial_clock_o = 1'b0;
		serial_io_o = 4'h5;
	end

	task automatic wait_sys(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask

	// Serial clock stands low between frames
	task automatic slot(input logic [3:0] v, inout logic [7:0] r);
		serial_io_o = v;
		wait_sys(4);
		serial_clock_o = 1'b1;
		wait_sys(2);
		r = {r[6:0], status_line_i};
		wait_sys(2);
		serial_clock_o = 1'b0;
	endtask

	task automatic send(input logic [7:0] q[$], input int aw, input int dw,
		input int tail, output logic [7:0] r);
		int w;
		r = 8'h00;
		chip_select_n_o = 1'b0;
		wait_sys(4);
		foreach (q[k]) begin
			w = (k == 0) ? 1 : ((k < 4) ? aw : dw);
			for (int i = 8 - w; i >= 0; i -= w)
				slot(4'((q[k] >> i) & ((1 << w) - 1)), r);
		end
		for (int i = 0; i < tail; i++)
			slot(4'h0, r);
		wait_sys(4);
		chip_select_n_o = 1'b1;
		// Released lines must not keep the last value
		serial_io_o = ~serial_io_o;
		wait_sys(8);
	endtask
endmodule

`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top import sfpw_pkg::*; ;
	localparam int PW = 600;
	logic        clk_sys_i, reset_i, cs_n, sck, rdy, write_enable_latch, busy, susp, vld, tsel;
	logic [3:0]  h_io, io_in, d_io, d_oe, bp;
	logic [23:0] m_addr;
	logic [7:0]  m_clr, r;
	logic [7:0]  seen [int];
	logic [7:0]  q [$];
	int          n_mismatch, samples_checked, n_req, cyc;

	assign io_in = {h_io[3:2], d_oe[1] ? d_io[1] : h_io[1], h_io[0]};

	sfpw_page_write #(.PAGE_WRITE_CYC(PW)) dut (.clk_sys_i(clk_sys_i),
		.reset_i(reset_i), .chip_select_n_i(cs_n), .serial_clock_i(sck),
		.serial_io_i(io_in), .serial_io_o(d_io), .serial_io_oe_o(d_oe),
		.block_protect_i(bp), .protect_top_bottom_select_i(tsel),
		.mem_valid_o(vld), .mem_addr_o(m_addr), .mem_clear_bits_o(m_clr),
		.mem_ready_i(rdy), .write_enable_latch_o(write_enable_latch),
		.write_in_progress_flag_o(busy), .program_suspended_o(susp));

	sfpw_host_model host (.clk_sys_i(clk_sys_i), .chip_select_n_o(cs_n),
		.serial_clock_o(sck), .serial_io_o(h_io), .status_line_i(io_in[1]));

	initial begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end

	// Array stalls one cycle in four
	always @(negedge clk_sys_i) begin
		cyc <= cyc + 1;
		rdy <= (cyc % 4) != 3;
	end

	always @(posedge clk_sys_i)
		if (vld && rdy) begin
			seen[m_addr] = m_clr;
			n_req++;
		end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	function automatic logic [7:0] dat(input int k);
		return 8'(k * 7 + 8'h31);
	endfunction

	task automatic frame(input logic [7:0] op, input int aw, input int dw,
		input logic [23:0] a, input int n, input int tail);
		q.delete();
		q.push_back(op);
		if (n > 0) begin
			q.push_back(a[23:16]);
			q.push_back(a[15:8]);
			q.push_back(a[7:0]);
			seen.delete();
			n_req = 0;
		end
		for (int k = 0; k < n; k++)
			q.push_back(dat(k));
		host.send(q, aw, dw, tail, r);
	endtask

	task automatic write_enable_command;
		frame(OP_WRITE_ENABLE_COMMAND, 1, 1, 0, 0, 0);
	endtask

	task automatic wait_idle;
		for (int i = 0; i < 3000 && busy !== 1'b0; i++)
			@(negedge clk_sys_i);
		chk(busy, 0);
	endtask

	task automatic expect_prog(input logic [23:0] a, input int n);
		int m;
		m = (n > 256) ? 256 : n;
		chk(n_req, m);
		for (int k = n - m; k < n; k++)
			chk(seen[{a[23:8], 8'(a[7:0] + k)}], dat(k) ^ 8'hFF);
	endtask

	task automatic t_no_enable;
		frame(OP_SINGLE_LINE_PAGE_WRITE, 1, 1, 24'h000010, 1, 0);
		chk(busy, 0);
		chk(n_req, 0);
	endtask

	task automatic t_wrap;
		write_enable_command();
		chk(write_enable_latch, 1);
		frame(OP_SINGLE_LINE_PAGE_WRITE, 1, 1, 24'h0123FE, 3, 0);
		chk({busy, write_enable_latch}, 2'b10);
		frame(OP_READ_STATUS, 1, 1, 0, 0, 8);
		chk(r, {1'b0, tsel, bp, 2'b01});
		frame(OP_READ_FLAG_STATUS, 1, 1, 0, 0, 8);
		chk(r & 8'h84, 8'h00);
		write_enable_command();
		chk(write_enable_latch, 0);
		wait_idle();
		chk(write_enable_latch, 0);
		expect_prog(24'h0123FE, 3);
	endtask

	task automatic t_lanes;
		logic [7:0]  op [4];
		int          aw [4];
		int          dw [4];
		logic [23:0] a;
		op = '{OP_TWO_LINE_DATA_PAGE_WRITE, OP_TWO_LINE_ADDR_DATA_PAGE_WRITE,
			OP_FOUR_LINE_DATA_PAGE_WRITE, OP_FOUR_LINE_ADDR_DATA_PAGE_WRITE};
		aw = '{1, 2, 1, 4};
		dw = '{2, 2, 4, 4};
		for (int i = 0; i < 4; i++) begin
			a = 24'h9C3A50 + 24'(i) * 24'h050203;
			write_enable_command();
			frame(op[i], aw[i], dw[i], a, 2, 0);
			wait_idle();
			expect_prog(a, 2);
		end
	endtask

	task automatic t_overflow;
		write_enable_command();
		frame(OP_FOUR_LINE_DATA_PAGE_WRITE, 1, 4, 24'h2B0007, 258, 0);
		wait_idle();
		expect_prog(24'h2B0007, 258);
	endtask

	task automatic t_refuse;
		write_enable_command();
		frame(OP_SINGLE_LINE_PAGE_WRITE, 1, 1, 24'h000100, 1, 4);
		chk({busy, write_enable_latch}, 2'b01);
		bp = 4'h9;
		frame(OP_SINGLE_LINE_PAGE_WRITE, 1, 1, 24'h000200, 1, 0);
		chk({busy, write_enable_latch}, 2'b01);
		chk(n_req, 0);
		// Top-end protection of the last sector
		bp = 4'h1;
		tsel = 1'b0;
		frame(OP_SINGLE_LINE_PAGE_WRITE, 1, 1, 24'hFF0300, 1, 0);
		chk({busy, write_enable_latch}, 2'b01);
		chk(n_req, 0);
		tsel = 1'b1;
		bp = 4'h0;
	endtask

	task automatic t_suspend;
		write_enable_command();
		frame(OP_SINGLE_LINE_PAGE_WRITE, 1, 1, 24'h3300F0, 1, 0);
		frame(OP_PROGRAM_ERASE_SUSPEND_CMD, 1, 1, 0, 0, 0);
		chk({busy, susp}, 2'b11);
		repeat (PW) @(negedge clk_sys_i);
		chk({busy, susp}, 2'b11);
		frame(OP_PROGRAM_ERASE_RESUME_CMD, 1, 1, 0, 0, 0);
		chk(susp, 0);
		wait_idle();
		expect_prog(24'h3300F0, 1);
	endtask

	initial begin
		reset_i = 1'b1;
		bp = 4'h0;
		tsel = 1'b1;
		rdy = 1'b0;
		cyc = 0;
		repeat (5) @(negedge clk_sys_i);
		reset_i = 1'b0;
		repeat (3) @(negedge clk_sys_i);
		t_no_enable();
		t_wrap();
		t_lanes();
		t_overflow();
		t_refuse();
		t_suspend();
		report_and_stop();
	end

	initial begin
		repeat (40000) @(posedge clk_sys_i);
		n_mismatch++;
		report_and_stop();
	end
endmodule

bind sfpw_page_write sfpw_page_write_asserts #(
	.PAGE_WRITE_CYC(PAGE_WRITE_CYC)) u_chk (.clk_sys_i(clk_sys_i),
	.reset_i(reset_i), .chip_select_n_i(chip_select_n_i),
	.serial_io_oe_o(serial_io_oe_o), .mem_valid_o(mem_valid_o),
	.mem_addr_o(mem_addr_o), .mem_clear_bits_o(mem_clear_bits_o),
	.mem_ready_i(mem_ready_i), .write_enable_latch_o(write_enable_latch_o),
	.write_in_progress_flag_o(write_in_progress_flag_o),
	.program_suspended_o(program_suspended_o));

`default_nettype wire
